// ### logic/kdd_device.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// ==========================================================
// device end: key derivation, revision query, digest generation
module kdd_device #(
  parameter logic [31:0] REVISION = 32'h0000_0a5c // arbitrary value
) (
  kdd_link_if.dev link, // command link
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, low
  input wire logic [15:0][15:0] slot_settings, // settings word per slot
  input wire logic config_locked, // configuration zone locked
  input wire logic [8:0][7:0] serial_bytes, // serial number bytes
  input wire logic nonce_we, // nonce command loads scratch
  input wire logic [255:0] nonce_value, // nonce value
  input wire logic nonce_origin, // nonce origin flag
  output logic [7:0] store_zone, // storage zone select
  output logic [15:0] store_id, // storage slot or block
  input wire logic [255:0] store_rdata, // storage read value
  output logic store_we, // key slot write pulse
  output logic [255:0] store_wdata, // key slot write value
  output logic sha_valid, // hash byte valid
  output logic [7:0] sha_byte, // hash message byte
  output logic sha_last, // last message byte
  input wire logic sha_ready, // hash engine takes byte
  input wire logic sha_done, // digest ready pulse
  input wire logic [255:0] sha_digest, // digest value
  output logic scratch_valid, // scratch digest valid
  output logic origin_indicator, // scratch origin flag
  output logic data_origin_marker, // scratch came from data slot
  output logic [15:0] scratch_slot, // slot recorded with marker
  output logic [7:0][7:0] usage_counter, // usage byte, slots 0-7
  output logic [7:0][7:0] refresh_tally // refresh count, slots 0-7
);
  typedef enum logic [2:0] {ST_RX, ST_EXEC, ST_FETCH, ST_HASH, ST_WAIT, ST_RESP} kdd_dst_t;
  typedef enum logic [1:0] {PH_MAC, PH_DERIVE, PH_GEN} kdd_ph_t;
  typedef struct packed {
    kdd_dst_t st;
    kdd_ph_t ph;
    logic [5:0] cnt;
    logic [35:0][7:0] buffer;
    logic [255:0] src;
    logic [255:0] tk;
    logic tk_valid;
    logic tk_origin;
    logic tk_gen;
    logic [15:0] tk_slot;
    logic [7:0][7:0] usage;
    logic [7:0][7:0] tally;
    logic [7:0] sel_zone;
    logic [15:0] sel_id;
    logic [6:0] msg_idx;
    logic [6:0] msg_len;
    logic use_extra;
    logic we;
    logic [255:0] wdata;
    logic [3:0] target;
    logic [3:0][7:0] rsp;
    logic [2:0] rsp_len;
    logic [2:0] rsp_idx;
  } kdd_dev_t;

  kdd_dev_t q, d;

  // roll uses the target itself, create uses the parent
  function automatic logic [3:0] source_slot(input logic [15:0] cfg, input logic [3:0] tgt);
    source_slot = cfg[kdd_pkg::CFG_CREATE] ? cfg[kdd_pkg::CFG_PARENT_LSB +: 4] : tgt;
  endfunction : source_slot

  // one layout serves mac, derived key and digest; only length and header source differ
  function automatic logic [7:0] msg_byte(input kdd_dev_t s, input logic [8:0][7:0] sn);
    logic [6:0] i;
    i = s.msg_idx;
    if (i < kdd_pkg::MSG_KEY_END)
      msg_byte = s.src[{i[4:0], 3'b000} +: 8];
    else if (i < kdd_pkg::MSG_HDR_END)
      msg_byte = s.use_extra ? s.buffer[{4'h1, i[1:0]}] : s.buffer[{4'h0, i[1:0]}];
    else if (i == kdd_pkg::MSG_SN8)
      msg_byte = sn[8];
    else if (i == kdd_pkg::MSG_SN0)
      msg_byte = sn[0];
    else if (i == kdd_pkg::MSG_SN1)
      msg_byte = sn[1];
    else if (i < kdd_pkg::MSG_ZERO_END)
      msg_byte = 8'h00;
    else
      msg_byte = s.tk[{i[4:0], 3'b000} +: 8];
  endfunction : msg_byte

  // ==========================================================
  // next state
  always_comb
  begin
    logic [7:0] op;
    logic [7:0] p1;
    logic [15:0] p2;
    logic [5:0] dlen;
    logic [3:0] tsel;
    logic [15:0] tcfg;
    logic [3:0] parent;
    logic [15:0] pcfg;
    logic extra;
    op = q.buffer[0];
    p1 = q.buffer[1];
    p2 = {q.buffer[3], q.buffer[2]};
    dlen = q.cnt - kdd_pkg::HDR_BYTES;
    tsel = q.st == ST_EXEC ? p2[3:0] : q.target;
    tcfg = slot_settings[tsel];
    parent = tcfg[kdd_pkg::CFG_PARENT_LSB +: 4];
    pcfg = slot_settings[parent];
    extra = p1 == kdd_pkg::ZONE_DATA && p2 < kdd_pkg::TRANSPORT_BASE && tcfg[kdd_pkg::CFG_VERIFY_ONLY];
    d = q;
    d.we = 1'b0;
    case (q.st)
      ST_RX:
        if (link.cmd_valid)
        begin
          if (q.cnt < kdd_pkg::BUF_BYTES)
            d.buffer[q.cnt] = link.cmd_byte;
          if (q.cnt != 6'h3f)
            d.cnt = q.cnt + 6'h01;
          if (link.cmd_last)
            d.st = ST_EXEC;
        end
      ST_EXEC:
      begin
        d.tk_valid = 1'b0;
        d.cnt = 6'h00;
        d.rsp_idx = 3'h0;
        d.rsp_len = 3'h1;
        d.rsp[0] = kdd_pkg::RES_OK;
        d.use_extra = 1'b0;
        d.st = ST_RESP;
        d.target = p2[3:0];
        if (q.cnt < kdd_pkg::HDR_BYTES || q.cnt > kdd_pkg::BUF_BYTES)
          d.rsp[0] = kdd_pkg::RES_PARSE;
        else
          case (op)
            kdd_pkg::OP_REVISION:
              if (p1 != 8'h00 || p2 != 16'h0000 || dlen != 6'h00)
                d.rsp[0] = kdd_pkg::RES_PARSE;
              else
              begin
                d.rsp = REVISION;
                d.rsp_len = 3'h4;
              end
            kdd_pkg::OP_DERIVE:
              if (!tcfg[kdd_pkg::CFG_DERIVE_EN])
                d.rsp[0] = kdd_pkg::RES_EXEC;
              else if ((p1 & kdd_pkg::P1_DERIVE_MASK) != 8'h00 ||
                       dlen != (tcfg[kdd_pkg::CFG_MAC_REQ] ? kdd_pkg::MAC_BYTES : 6'h00))
                d.rsp[0] = kdd_pkg::RES_PARSE;
              else if (p1[kdd_pkg::P1_ORIGIN_BIT] != q.tk_origin || !q.tk_valid)
                d.rsp[0] = kdd_pkg::RES_EXEC;
              // only the parent's limit is looked at; the target's own is never consulted
              else if ((tcfg[kdd_pkg::CFG_CREATE] || tcfg[kdd_pkg::CFG_MAC_REQ]) &&
                       pcfg[kdd_pkg::CFG_USAGE_LIMITED] && !parent[3] &&
                       q.usage[parent[2:0]] == kdd_pkg::USAGE_EMPTY)
                d.rsp[0] = kdd_pkg::RES_EXEC;
              else
              begin
                d.sel_zone = kdd_pkg::ZONE_DATA;
                d.st = ST_FETCH;
                if (tcfg[kdd_pkg::CFG_MAC_REQ])
                begin
                  d.sel_id = {12'h000, parent};
                  d.ph = PH_MAC;
                  d.msg_len = kdd_pkg::MSG_MAC_LEN;
                end
                else
                begin
                  d.sel_id = {12'h000, source_slot(tcfg, p2[3:0])};
                  d.ph = PH_DERIVE;
                  d.msg_len = kdd_pkg::MSG_LEN;
                end
              end
            kdd_pkg::OP_DIGEST_GEN_CMD:
              if (p1 > kdd_pkg::ZONE_DATA)
                d.rsp[0] = kdd_pkg::RES_PARSE;
              else if (!q.tk_valid)
                d.rsp[0] = kdd_pkg::RES_EXEC;
              else if (p1 == kdd_pkg::ZONE_CONFIG && !config_locked)
                d.rsp[0] = kdd_pkg::RES_EXEC;
              else if (extra && dlen < kdd_pkg::EXTRA_BYTES)
                d.rsp[0] = kdd_pkg::RES_PARSE;
              else
              begin
                d.sel_zone = p1;
                d.sel_id = (p1 == kdd_pkg::ZONE_DATA && p2 < kdd_pkg::TRANSPORT_BASE) ? {12'h000, p2[3:0]} : p2;
                d.use_extra = extra;
                d.ph = PH_GEN;
                d.msg_len = kdd_pkg::MSG_LEN;
                d.st = ST_FETCH;
              end
            default: d.rsp[0] = kdd_pkg::RES_PARSE;
          endcase
      end
      ST_FETCH:
      begin
        d.src = store_rdata;
        d.msg_idx = 7'h00;
        d.st = ST_HASH;
      end
      ST_HASH:
        if (sha_ready)
        begin
          if (q.msg_idx == q.msg_len - 7'h01)
            d.st = ST_WAIT;
          else
            d.msg_idx = q.msg_idx + 7'h01;
        end
      ST_WAIT:
        if (sha_done)
        begin
          d.st = ST_RESP;
          case (q.ph)
            PH_MAC:
              if (sha_digest != q.buffer[35:4])
                d.rsp[0] = kdd_pkg::RES_EXEC;
              else
              begin
                d.sel_id = {12'h000, source_slot(tcfg, q.target)};
                d.ph = PH_DERIVE;
                d.msg_len = kdd_pkg::MSG_LEN;
                d.st = ST_FETCH;
              end
            PH_DERIVE:
            begin
              // the slot is written only here, after every check passed
              d.we = 1'b1;
              d.wdata = sha_digest;
              d.sel_id = {12'h000, q.target};
              if (!q.target[3])
              begin
                d.usage[q.target[2:0]] = kdd_pkg::USAGE_FRESH;
                d.tally[q.target[2:0]] = q.tally[q.target[2:0]] + 8'h01;
              end
            end
            PH_GEN:
            begin
              d.tk = sha_digest;
              d.tk_valid = 1'b1;
              d.tk_gen = q.sel_zone == kdd_pkg::ZONE_DATA && p2 <= kdd_pkg::DATA_SLOT_MAX;
              if (d.tk_gen)
                d.tk_slot = p2;
            end
            default: d.st = ST_RESP;
          endcase
        end
      ST_RESP:
        if (link.rsp_ready)
        begin
          if (q.rsp_idx == q.rsp_len - 3'h1)
            d.st = ST_RX;
          else
            d.rsp_idx = q.rsp_idx + 3'h1;
        end
      default: d.st = ST_RX;
    endcase
    // a nonce load is only accepted between commands
    if (nonce_we && q.st == ST_RX)
    begin
      d.tk = nonce_value;
      d.tk_valid = 1'b1;
      d.tk_origin = nonce_origin;
      d.tk_gen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      q <= '{st: ST_RX, ph: PH_GEN, usage: {8{kdd_pkg::USAGE_RST}}, tally: {8{kdd_pkg::TALLY_RST}}, default: '0};
    else
      q <= d;
  end

  // ==========================================================
  // outputs; the scratch value itself has no port
  assign link.cmd_ready = q.st == ST_RX;
  assign link.rsp_valid = q.st == ST_RESP;
  assign link.rsp_byte = q.rsp[q.rsp_idx[1:0]];
  assign link.rsp_last = q.rsp_idx == q.rsp_len - 3'h1;
  assign store_zone = q.sel_zone;
  assign store_id = q.sel_id;
  assign store_we = q.we;
  assign store_wdata = q.wdata;
  assign sha_valid = q.st == ST_HASH;
  assign sha_byte = msg_byte(q, serial_bytes);
  assign sha_last = q.msg_idx == q.msg_len - 7'h01;
  assign scratch_valid = q.tk_valid;
  assign origin_indicator = q.tk_origin;
  assign data_origin_marker = q.tk_gen;
  assign scratch_slot = q.tk_slot;
  assign usage_counter = q.usage;
  assign refresh_tally = q.tally;
endmodule : kdd_device

// ### logic/kdd_pkg.sv
// ==========================================================
// shared constants for the command link and both ends
package kdd_pkg;
  // ==========================================================
  // opcodes and zones
  localparam logic [7:0] OP_DERIVE = 8'h1c;
  localparam logic [7:0] OP_REVISION = 8'h30;
  localparam logic [7:0] OP_DIGEST_GEN_CMD = 8'h15;
  localparam logic [7:0] ZONE_CONFIG = 8'h00;
  localparam logic [7:0] ZONE_OTP = 8'h01;
  localparam logic [7:0] ZONE_DATA = 8'h02;
  // ==========================================================
  // slot_settings field positions
  localparam int CFG_MAC_REQ = 15;
  localparam int CFG_DERIVE_EN = 13;
  localparam int CFG_CREATE = 12;
  localparam int CFG_PARENT_LSB = 8;
  localparam int CFG_VERIFY_ONLY = 7;
  localparam int CFG_USAGE_LIMITED = 5;
  // ==========================================================
  // first_param of key derivation
  localparam int P1_ORIGIN_BIT = 2;
  localparam logic [7:0] P1_DERIVE_MASK = 8'hfb;
  // ==========================================================
  // result codes
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_PARSE = 8'h03;
  localparam logic [7:0] RES_EXEC = 8'h0f;
  // ==========================================================
  // slot identifiers and usage bytes
  localparam logic [15:0] TRANSPORT_BASE = 16'h8000;
  localparam logic [15:0] DATA_SLOT_MAX = 16'h000f;
  localparam logic [7:0] USAGE_FRESH = 8'hff;
  localparam logic [7:0] USAGE_EMPTY = 8'h00;
  localparam logic [7:0] USAGE_RST = 8'hff;
  localparam logic [7:0] TALLY_RST = 8'h00;
  // ==========================================================
  // frame and message layout, in bytes
  localparam logic [5:0] HDR_BYTES = 6'h04;
  localparam logic [5:0] MAC_BYTES = 6'h20;
  localparam logic [5:0] EXTRA_BYTES = 6'h04;
  localparam logic [5:0] BUF_BYTES = 6'h24;
  localparam logic [5:0] MAX_DATA = 6'h20;
  localparam logic [6:0] MSG_KEY_END = 7'h20;
  localparam logic [6:0] MSG_HDR_END = 7'h24;
  localparam logic [6:0] MSG_SN8 = 7'h24;
  localparam logic [6:0] MSG_SN0 = 7'h25;
  localparam logic [6:0] MSG_SN1 = 7'h26;
  localparam logic [6:0] MSG_MAC_LEN = 7'h27;
  localparam logic [6:0] MSG_ZERO_END = 7'h40;
  localparam logic [6:0] MSG_LEN = 7'h60;
  // ==========================================================
  // host register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD = 12'h004;
  localparam logic [11:0] REG_DLEN = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam logic [11:0] REG_RESP = 12'h010;
  localparam logic [11:0] REG_DATA0 = 12'h020;
  localparam logic [11:0] REG_DATA7 = 12'h03c;
endpackage : kdd_pkg

// ### logic/kdd_link_if.sv
`timescale 1ns/1ns
// ==========================================================
// byte link between host and device, both on clk_sys
interface kdd_link_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_last;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_last;
  logic rsp_ready;
  modport dev (input cmd_valid, cmd_byte, cmd_last, rsp_ready, output cmd_ready, rsp_valid, rsp_byte, rsp_last);
  modport host (output cmd_valid, cmd_byte, cmd_last, rsp_ready, input cmd_ready, rsp_valid, rsp_byte, rsp_last);
endinterface : kdd_link_if

// ### logic/kdd_host.sv
`timescale 1ns/1ns
// ==========================================================
// host end: apb registers in, command frames out
module kdd_host (
  kdd_link_if.host link, // command link
  input wire logic clk_sys, // system clock
  input wire logic rstn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr // apb error, unmapped
);
  typedef enum logic [1:0] {H_IDLE, H_TX, H_RX} kdd_hst_t;
  typedef struct packed {
    kdd_hst_t st;
    logic [31:0] cmd;
    logic [5:0] dlen;
    logic [7:0][31:0] data;
    logic [31:0] resp;
    logic [5:0] rcount;
    logic done;
    logic refused;
    logic [5:0] idx;
    logic ack;
    logic [31:0] rdata;
    logic err;
  } kdd_host_t;

  kdd_host_t q, d;

  function automatic logic mapped(input logic [11:0] a);
    mapped = a == kdd_pkg::REG_CTRL || a == kdd_pkg::REG_CMD || a == kdd_pkg::REG_DLEN ||
             a == kdd_pkg::REG_STATUS || a == kdd_pkg::REG_RESP ||
             (a >= kdd_pkg::REG_DATA0 && a <= kdd_pkg::REG_DATA7 && a[1:0] == 2'b00);
  endfunction : mapped

  function automatic logic [7:0] tx_byte(input kdd_host_t s);
    logic [5:0] j;
    j = s.idx - kdd_pkg::HDR_BYTES;
    if (s.idx < kdd_pkg::HDR_BYTES)
      tx_byte = s.cmd[{s.idx[1:0], 3'b000} +: 8];
    else
      tx_byte = s.data[j[4:2]][{j[1:0], 3'b000} +: 8];
  endfunction : tx_byte

  // ==========================================================
  // next state
  always_comb
  begin
    logic access;
    access = psel && penable;
    d = q;
    d.ack = access && !q.ack;
    if (access && !q.ack)
    begin
      d.err = !mapped(paddr);
      d.rdata = 32'h0000_0000;
      case (paddr)
        kdd_pkg::REG_CMD: d.rdata = q.cmd;
        kdd_pkg::REG_DLEN: d.rdata = {26'h0000000, q.dlen};
        kdd_pkg::REG_STATUS: d.rdata = {18'h00000, q.rcount, 5'h00, q.refused, q.done, q.st != H_IDLE};
        kdd_pkg::REG_RESP: d.rdata = q.resp;
        default:
          if (paddr >= kdd_pkg::REG_DATA0 && paddr <= kdd_pkg::REG_DATA7)
            d.rdata = q.data[paddr[4:2]];
      endcase
    end
    // writes land on the edge that completes the access
    if (access && q.ack && pwrite && !q.err)
    begin
      case (paddr)
        kdd_pkg::REG_CMD:
          if (q.st == H_IDLE)
            d.cmd = pwdata;
        kdd_pkg::REG_DLEN:
          if (q.st == H_IDLE)
            d.dlen = pwdata > {26'h0000000, kdd_pkg::MAX_DATA} ? kdd_pkg::MAX_DATA : pwdata[5:0];
        kdd_pkg::REG_CTRL:
        begin
          if (pwdata[1])
            d.done = 1'b0;
          if (pwdata[2])
            d.refused = 1'b0;
          // software is expected to load the nonce before a derivation start
          if (pwdata[0] && q.st == H_IDLE)
          begin
            if (q.cmd[7:0] == kdd_pkg::OP_DIGEST_GEN_CMD && q.cmd[15:8] > kdd_pkg::ZONE_DATA)
              d.refused = 1'b1;
            else
            begin
              d.st = H_TX;
              d.idx = 6'h00;
              d.rcount = 6'h00;
              d.resp = 32'h0000_0000;
              if (q.cmd[7:0] == kdd_pkg::OP_DERIVE)
                d.cmd[15:8] = q.cmd[15:8] & ~kdd_pkg::P1_DERIVE_MASK;
              if (q.cmd[7:0] == kdd_pkg::OP_REVISION)
              begin
                d.cmd[31:8] = 24'h000000;
                d.dlen = 6'h00;
              end
            end
          end
        end
        default:
          if (paddr >= kdd_pkg::REG_DATA0 && paddr <= kdd_pkg::REG_DATA7 && q.st == H_IDLE)
            d.data[paddr[4:2]] = pwdata;
      endcase
    end
    case (q.st)
      H_TX:
        if (link.cmd_ready)
        begin
          if (link.cmd_last)
            d.st = H_RX;
          else
            d.idx = q.idx + 6'h01;
        end
      H_RX:
        if (link.rsp_valid)
        begin
          if (q.rcount < 6'h04)
            d.resp[{q.rcount[1:0], 3'b000} +: 8] = link.rsp_byte;
          if (q.rcount != 6'h3f)
            d.rcount = q.rcount + 6'h01;
          if (link.rsp_last)
          begin
            d.st = H_IDLE;
            d.done = 1'b1;
          end
        end
      default: ;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      q <= '{st: H_IDLE, default: '0};
    else
      q <= d;
  end

  assign pready = q.ack;
  assign prdata = q.rdata;
  assign pslverr = q.ack && q.err;
  assign link.cmd_valid = q.st == H_TX;
  assign link.cmd_byte = tx_byte(q);
  assign link.cmd_last = q.idx == kdd_pkg::HDR_BYTES - 6'h01 + q.dlen;
  assign link.rsp_ready = q.st == H_RX;
endmodule : kdd_host

// ### dv/kdd_chk.sv
`timescale 1ns/1ns
// ==========================================================
// link checker
module kdd_chk #(
  parameter logic [31:0] REVISION = 32'h0000_0a5c // arbitrary value
) (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, low
  input wire logic cmd_valid, // command byte valid
  input wire logic [7:0] cmd_byte, // command byte
  input wire logic cmd_last, // last command byte
  input wire logic cmd_ready, // device idle
  input wire logic rsp_valid, // response valid
  input wire logic [7:0] rsp_byte, // response byte
  input wire logic rsp_last, // last response byte
  input wire logic rsp_ready // host takes response
);
  logic [5:0] idx_q;
  logic [7:0] op_q;
  logic [2:0] nrsp_q;
  wire logic tk = cmd_valid && cmd_ready;
  wire logic rk = rsp_valid && rsp_ready;
  // op_q stays valid until the next frame starts
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      idx_q <= 6'h00;
      op_q <= 8'h00;
      nrsp_q <= 3'h0;
    end
    else
    begin
      if (tk)
        idx_q <= cmd_last ? 6'h00 : idx_q + 6'h01;
      if (tk && idx_q == 6'h00)
        op_q <= cmd_byte;
      if (rk)
        nrsp_q <= rsp_last ? 3'h0 : nrsp_q + 3'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_rev_params: assert property (tk && idx_q != 6'h00 && op_q == kdd_pkg::OP_REVISION |->
    cmd_byte == 8'h00 && cmd_last == (idx_q == 6'h03)) else $error("revision frame malformed");
  a_derive_p1: assert property (tk && idx_q == 6'h01 && op_q == kdd_pkg::OP_DERIVE |->
    (cmd_byte & kdd_pkg::P1_DERIVE_MASK) == 8'h00) else $error("derive first_param has stray bits");
  a_zone_legal: assert property (tk && idx_q == 6'h01 && op_q == kdd_pkg::OP_DIGEST_GEN_CMD |->
    cmd_byte <= kdd_pkg::ZONE_DATA) else $error("reserved zone sent");
  a_rev_answer: assert property (tk && cmd_last && op_q == kdd_pkg::OP_REVISION |->
    ##[1:3] rsp_valid) else $error("revision answer late");
  a_rev_value: assert property (rk && op_q == kdd_pkg::OP_REVISION |->
    rsp_byte == REVISION[8 * nrsp_q +: 8]) else $error("revision byte wrong");
  a_rsp_count: assert property (rk && rsp_last |->
    nrsp_q == (op_q == kdd_pkg::OP_REVISION ? 3'h3 : 3'h0)) else $error("response length wrong");
  a_busy_exec: assert property (tk && cmd_last |=> !cmd_ready [*2]) else $error("ready while executing");
  a_rsp_hold: assert property (rsp_valid && !(rsp_ready && rsp_last) |=> rsp_valid && (rsp_ready || $stable(rsp_byte)))
    else $error("response dropped");
  a_ready_back: assert property (rk && rsp_last |-> ##[1:2] cmd_ready) else $error("device stays busy");
endmodule : kdd_chk

// ### dv/key_derive_digest_commands_tb.sv
`timescale 1ns/1ns
module key_derive_digest_commands_tb;
  typedef struct packed {logic [31:0] cmd; logic nz; logic ok; logic [7:0] src;} kdd_row_t;
  localparam logic [31:0] REV = 32'h0000_0a5c; // arbitrary value
  localparam logic [255:0] DIG = {8{32'h5a3c_9617}};
  localparam logic [255:0] NONCE = {8{32'h0f1e_2d3c}};
  localparam kdd_row_t ROWS [11] = '{'{32'h0002_0215, 0, 0, 0}, '{32'h0002_0215, 1, 1, 0},
    '{32'h0000_0015, 1, 0, 0}, '{32'h0001_0115, 1, 1, 0}, '{32'h0006_0215, 1, 0, 0}, '{32'h0001_001c, 1, 1, 1},
    '{32'h0001_041c, 1, 0, 0}, '{32'h0004_001c, 1, 0, 0}, '{32'h0001_001c, 0, 0, 0}, '{32'h0002_001c, 1, 1, 3},
    '{32'h0005_001c, 1, 0, 0}};
  logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nonce_we = 1'b0;
  logic lock = 1'b0, org = 1'b0, origin_indicator;
  logic pready, pslverr, er, store_we, sha_valid, sha_last, done_q = 1'b0, scratch_valid, data_origin_marker;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic [15:0][15:0] slot_settings = {144'h0, 16'h0080, 16'ha300, 16'h0000, 16'h0020, 16'h3300, 16'h2000, 16'h0};
  logic [7:0] store_zone, sha_byte;
  logic [15:0] store_id, scratch_slot;
  logic [255:0] store_wdata, wr_q;
  logic [7:0][7:0] usage_counter, refresh_tally;
  logic [7:0] msg [$];
  int failures = 0, num_checks = 0, wr_cnt = 0, w0, dl = 0;
  wire logic [255:0] store_rdata = {32{store_id[7:0] ^ 8'ha0}};
  kdd_link_if link ();
  kdd_host u_kdd_host (.link(link), .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  kdd_device #(.REVISION(REV)) u_kdd_device (.link(link), .clk_sys(clk_sys), .rstn(rstn),
    .slot_settings(slot_settings), .config_locked(lock), .serial_bytes(72'h12_3456_789a_bcde_f011),
    .nonce_we(nonce_we), .nonce_value(NONCE), .nonce_origin(org), .store_zone(store_zone), .store_id(store_id),
    .store_rdata(store_rdata), .store_we(store_we), .store_wdata(store_wdata), .sha_valid(sha_valid),
    .sha_byte(sha_byte), .sha_last(sha_last), .sha_ready(1'b1), .sha_done(done_q), .sha_digest(DIG),
    .scratch_valid(scratch_valid), .origin_indicator(origin_indicator), .data_origin_marker(data_origin_marker),
    .scratch_slot(scratch_slot), .usage_counter(usage_counter), .refresh_tally(refresh_tally));
  kdd_chk #(.REVISION(REV)) u_kdd_chk (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(link.cmd_valid),
    .cmd_byte(link.cmd_byte), .cmd_last(link.cmd_last), .cmd_ready(link.cmd_ready), .rsp_valid(link.rsp_valid),
    .rsp_byte(link.rsp_byte), .rsp_last(link.rsp_last), .rsp_ready(link.rsp_ready));
  always #20 clk_sys = ~clk_sys;
  // ==========================================================
  // hash engine and key store stand-ins
  always @(posedge clk_sys)
  begin
    done_q <= sha_valid && sha_last;
    if (sha_valid)
      msg.push_back(sha_byte);
    if (store_we)
    begin
      wr_cnt++;
      wr_q <= store_wdata;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      stop_test();
    end
  endtask : apb
  // leaves status in st and the response word in rd
  task automatic run(input logic [31:0] c, input logic nz);
    int n = 0;
    msg.delete();
    if (nz)
    begin
      @(posedge clk_sys);
      nonce_we <= 1'b1;
      @(posedge clk_sys);
      nonce_we <= 1'b0;
    end
    apb(1'b1, kdd_pkg::REG_CMD, c);
    apb(1'b1, kdd_pkg::REG_DLEN, dl);
    apb(1'b1, kdd_pkg::REG_CTRL, 32'h0000_0007);
    do
    begin
      apb(1'b0, kdd_pkg::REG_STATUS, 32'h0);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 400);
    st = rd;
    if (n >= 400)
    begin
      failures++;
      stop_test();
    end
    apb(1'b0, kdd_pkg::REG_RESP, 32'h0);
  endtask : run
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    check({link.cmd_ready, scratch_valid, usage_counter[0], refresh_tally[7]}, 32'h2ff00);
    foreach (ROWS[i])
    begin
      w0 = wr_cnt;
      run(ROWS[i].cmd, ROWS[i].nz);
      check(st[13:8], 32'h1);
      check(rd[7:0] == kdd_pkg::RES_OK, ROWS[i].ok);
      check(scratch_valid, ROWS[i].ok && ROWS[i].cmd[7:0] == kdd_pkg::OP_DIGEST_GEN_CMD);
      check(wr_cnt - w0, ROWS[i].ok && ROWS[i].cmd[7:0] == kdd_pkg::OP_DERIVE);
      if (ROWS[i].src != 8'h00)
      begin
        check({msg[35], msg[34], msg[33], msg[32]}, ROWS[i].cmd);
        check({msg[0], msg[36], msg[37], msg[64]}, {ROWS[i].src ^ 8'ha0, 24'h12113c});
        check(wr_q[255:224], DIG[255:224]);
      end
    end
    check({refresh_tally[1], refresh_tally[2], refresh_tally[4], usage_counter[1]}, 32'h010100ff);
    run(32'h0002_0215, 1'b1);
    check({data_origin_marker, scratch_slot}, 32'h10002);
    run(32'h8001_0215, 1'b1);
    check({rd[7:0], data_origin_marker}, 32'h0);
    run(32'h0000_0030, 1'b0);
    check(st[13:8], 32'h4);
    check(rd, REV);
    check(scratch_valid, 32'h0);
    org <= 1'b1;
    run(32'h0001_041c, 1'b1);
    check({rd[7:0], origin_indicator}, 32'h1);
    lock <= 1'b1;
    run(32'h0000_0015, 1'b1);
    check(rd[7:0], 32'h0);
    // mac equals the stand-in digest, so the check must pass
    dl = 32;
    for (int k = 0; k < 8; k++)
      apb(1'b1, kdd_pkg::REG_DATA0 + 12'(4 * k), DIG[31:0]);
    run(32'h0005_041c, 1'b1);
    check({rd[7:0], msg[38], msg[71], refresh_tally[5]}, 32'h00f01c01);
    run(32'h0006_0215, 1'b1);
    check({msg[35], msg[34], msg[33], msg[32]}, DIG[31:0]);
    apb(1'b1, kdd_pkg::REG_CMD, 32'h0003_0315);
    apb(1'b1, kdd_pkg::REG_CTRL, 32'h0000_0007);
    apb(1'b0, kdd_pkg::REG_STATUS, 32'h0);
    check(rd[2:0], 32'h4);
    apb(1'b0, 12'h040, 32'h0);
    check(er, 32'h1);
    rstn <= 1'b0;
    @(posedge clk_sys);
    rstn <= 1'b1;
    check({refresh_tally[5], usage_counter[5], scratch_valid}, 32'h1fe);
    stop_test();
  end
endmodule : key_derive_digest_commands_tb
